/* core/second_tick.sv */
/*
  Divider giving a one-cycle pulse once per second of system clock.
  Assumes a free-running clock at the configured rate.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wind_status_cfg.svh"

module second_tick #(
  parameter int unsigned CYCLES_PER_TICK = `CLK_FREQ_HZ
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  logic [26:0] cnt_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q  <= 27'h0;
      o_tick <= 1'b0;
    end
    else if (cnt_q == 27'(CYCLES_PER_TICK - 1))
    begin
      cnt_q  <= 27'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 27'h1;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* core/wind_status_builder.sv */
/*
  Builds the extended 32-bit status word and the compact 8-bit status
  byte from the fault detectors, heater control, buffer fill and restart.
  Assumes detector inputs are synchronous to i_ref_clk, except the two
  heater levels which come from outside and are synchronised here.
*/
// Behaviour
// - averaging under 10 s: fault when no fresh sample for 10 s.
// - averaging 10 s or more: fault when buffer holds under half.
// - heating criterion at extended bit 1 and compact bit 6.
// - heater on at extended bit 2 and compact bit 7.
// - static fault at extended bit 4, compact bit 5, incl. no samples 1 min.
// - extended bits 8-11 give fill in sixteenths, n/16 < x <= (n+1)/16.
// - compact bits 1-3 give fill in eighths, n/8 < x <= (n+1)/8.
// - restart flag bit 13 set by restart, cleared after first telegram.
// - compact byte uses same sources as extended word.
// - fill is occupied memory over memory required for averaging period.
`timescale 1ns/10ps
`default_nettype none
`include "wind_status_cfg.svh"

module wind_status_builder #(
  parameter int unsigned CYCLES_PER_SEC = `CLK_FREQ_HZ
)
(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_sample_valid,
  input  wire logic                       i_temp_out_of_range,
  input  wire logic                       i_heat_criterion,
  input  wire logic                       i_heat_on,
  input  wire wind_status_pkg::sample_cnt_t i_buf_used,
  input  wire wind_status_pkg::sample_cnt_t i_buf_required,
  input  wire wind_status_pkg::avg_time_t i_avg_time_s,
  input  wire logic                       i_restart,
  input  wire logic                       i_telegram_done,
  output wind_status_pkg::ext_word_t      o_extended_status_word,
  output wind_status_pkg::cmp_byte_t      o_compact_status_byte
);
  import wind_status_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // smallest n with used*steps <= (n+1)*required; zero required gives steps-1
  function automatic logic [3:0] fill_code(input sample_cnt_t used,
                                           input sample_cnt_t req,
                                           input int unsigned steps);
    logic [35:0] lhs;
    logic [35:0] rhs;
    logic [3:0]  code;
    lhs  = 36'(used) * 36'(steps);
    code = 4'(steps - 1);
    for (int k = int'(steps) - 1; k >= 0; k--)
    begin
      rhs = 36'(req) * 36'(k + 1);
      if (lhs <= rhs)
        code = 4'(k);
    end
    if (req == 16'h0)
      code = 4'(steps - 1);
    return code;
  endfunction

  // ----------------------------------------------------------------------
  // synchronise heater levels (three stages, second and third agree)
  // ----------------------------------------------------------------------
  logic [2:0] crit_sync_q;
  logic [2:0] heat_sync_q;
  logic       crit_q;
  logic       heat_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      crit_sync_q <= 3'h0;
      heat_sync_q <= 3'h0;
      crit_q      <= 1'b0;
      heat_q      <= 1'b0;
    end
    else
    begin
      crit_sync_q <= {crit_sync_q[1:0], i_heat_criterion};
      heat_sync_q <= {heat_sync_q[1:0], i_heat_on};
      if (crit_sync_q[1] == crit_sync_q[2])
        crit_q <= crit_sync_q[2];
      if (heat_sync_q[1] == heat_sync_q[2])
        heat_q <= heat_sync_q[2];
    end
  end

  // ----------------------------------------------------------------------
  // staleness timers in whole seconds
  // ----------------------------------------------------------------------
  logic       sec_tick;
  logic [6:0] stale_sec_q;

  second_tick #(
    .CYCLES_PER_TICK (CYCLES_PER_SEC)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (sec_tick)
  );

  // counts seconds since the last fresh sample; saturates past the static span
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stale_sec_q <= 7'h0;
    else if (i_sample_valid)
      stale_sec_q <= 7'h0;
    else if (sec_tick && stale_sec_q <= 7'(`STATIC_SPAN_S))
      stale_sec_q <= stale_sec_q + 7'h1;
  end

  // ----------------------------------------------------------------------
  // condition sources
  // ----------------------------------------------------------------------
  logic       short_avg;
  logic       gen_fault;
  logic       static_fault;
  logic [3:0] fill16;
  logic [2:0] fill8;

  always_comb
  begin
    short_avg    = i_avg_time_s < 16'(`SHORT_AVG_LIMIT_S);
    // under half of one sample per second of window
    // tick phase against the sample is unknown: one extra tick guarantees a full span
    gen_fault    = short_avg ? (stale_sec_q > 7'(`STALE_SPAN_S))
                             : (32'(i_buf_used) * 32'd100 <
                                32'(i_avg_time_s) * 32'(`MIN_FILL_PERCENT));
    static_fault = i_temp_out_of_range || (stale_sec_q > 7'(`STATIC_SPAN_S));
    fill16       = fill_code(i_buf_used, i_buf_required, 16);
    fill8        = 3'(fill_code(i_buf_used, i_buf_required, 8));
  end

  // ----------------------------------------------------------------------
  // restart flag
  // ----------------------------------------------------------------------
  restart_state_t rst_state_q;

  // a restart in the same cycle as telegram completion keeps the flag set
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_state_q <= RST_PENDING;
    else
    begin
      unique case (rst_state_q)
        RST_PENDING:
          if (i_telegram_done && !i_restart)
            rst_state_q <= RST_CLEARED;
        RST_CLEARED:
          if (i_restart)
            rst_state_q <= RST_PENDING;
        default:
          rst_state_q <= RST_PENDING;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output words
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_extended_status_word <= `EXT_RESET_VALUE;
      o_compact_status_byte  <= `CMP_RESET_VALUE;
    end
    else
    begin
      o_extended_status_word                                  <= 32'h0;
      o_extended_status_word[`EXT_GEN_FAULT_BIT]              <= gen_fault;
      o_extended_status_word[`EXT_HEAT_CRIT_BIT]              <= crit_q;
      o_extended_status_word[`EXT_HEAT_ON_BIT]                <= heat_q;
      o_extended_status_word[`EXT_STATIC_BIT]                 <= static_fault;
      o_extended_status_word[`EXT_FILL_MSB:`EXT_FILL_LSB]     <= fill16;
      o_extended_status_word[`EXT_RESTART_BIT]                <= (rst_state_q == RST_PENDING);
      // same sources as the wide word so shared flags never disagree
      o_compact_status_byte                                   <= 8'h00;
      o_compact_status_byte[`CMP_GEN_FAULT_BIT]               <= gen_fault;
      o_compact_status_byte[`CMP_FILL_MSB:`CMP_FILL_LSB]      <= fill8;
      o_compact_status_byte[`CMP_STATIC_BIT]                  <= static_fault;
      o_compact_status_byte[`CMP_HEAT_CRIT_BIT]               <= crit_q;
      o_compact_status_byte[`CMP_HEAT_ON_BIT]                 <= heat_q;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  shared_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_extended_status_word[0] == o_compact_status_byte[0] &&
    o_extended_status_word[4] == o_compact_status_byte[5] &&
    o_extended_status_word[1] == o_compact_status_byte[6] &&
    o_extended_status_word[2] == o_compact_status_byte[7])
    else $error("shared flags differ");

  reserved_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_extended_status_word & 32'hffff_d0e8) == 32'h0 && !o_compact_status_byte[4])
    else $error("reserved bit set");

  // both bounds on the registered code, so a stuck or shifted code cannot pass
  fill_coarse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_buf_required != 16'h0 && i_buf_used != 16'h0 && i_buf_used <= i_buf_required |=>
      36'($past(i_buf_used)) * 36'd8 <= 36'($past(i_buf_required)) * 36'(o_compact_status_byte[3:1] + 4'h1) &&
      36'($past(i_buf_used)) * 36'd8 > 36'($past(i_buf_required)) * 36'(o_compact_status_byte[3:1]))
    else $error("compact fill wrong");

  fill_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_buf_required != 16'h0 && i_buf_used != 16'h0 && i_buf_used <= i_buf_required |=>
      36'($past(i_buf_used)) * 36'd16 <= 36'($past(i_buf_required)) * 36'(o_extended_status_word[11:8] + 5'h1) &&
      36'($past(i_buf_used)) * 36'd16 > 36'($past(i_buf_required)) * 36'(o_extended_status_word[11:8]))
    else $error("extended fill bound wrong");

  restart_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rst_state_q == RST_PENDING && i_telegram_done && !i_restart |=> ##1 !o_extended_status_word[13])
    else $error("restart flag not cleared");

  restart_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_restart |=> ##1 o_extended_status_word[13])
    else $error("restart flag not set");

  stale_fault_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    short_avg && stale_sec_q > 7'd10 && !i_sample_valid |=> o_extended_status_word[0])
    else $error("stale fault missing");

  heat_track_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    heat_sync_q[1] && heat_sync_q[2] |=> ##1 o_extended_status_word[2])
    else $error("heater flag not following");

  half_fill_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !short_avg && 32'(i_buf_used) * 32'd2 < 32'(i_avg_time_s) |=> o_compact_status_byte[0])
    else $error("low fill fault missing");

  static_fault_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_temp_out_of_range |=> o_extended_status_word[4])
    else $error("static fault missing");

  restart_cleared_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_extended_status_word[13] ##1 !o_extended_status_word[13]);
  stale_fault_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    short_avg && o_compact_status_byte[0]);
  full_buffer_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_extended_status_word[11:8] == 4'hf);

endmodule
`default_nettype wire

/* include/wind_status_cfg.svh */
/*
  Constants for the wind sensor status word builder: field positions,
  timing figures and reset values.
  Assumes a 100 MHz system clock.
*/
`ifndef WIND_STATUS_CFG_SVH
`define WIND_STATUS_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ          100000000
`define STALE_SPAN_S         10
`define STATIC_SPAN_S        60
`define SHORT_AVG_LIMIT_S    10
`define MIN_FILL_PERCENT     50

// ----------------------------------------------------------------------
// extended word field positions
// ----------------------------------------------------------------------
`define EXT_GEN_FAULT_BIT    0
`define EXT_HEAT_CRIT_BIT    1
`define EXT_HEAT_ON_BIT      2
`define EXT_STATIC_BIT       4
`define EXT_FILL_LSB         8
`define EXT_FILL_MSB         11
`define EXT_RESTART_BIT      13

// ----------------------------------------------------------------------
// compact byte field positions
// ----------------------------------------------------------------------
`define CMP_GEN_FAULT_BIT    0
`define CMP_FILL_LSB         1
`define CMP_FILL_MSB         3
`define CMP_STATIC_BIT       5
`define CMP_HEAT_CRIT_BIT    6
`define CMP_HEAT_ON_BIT      7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EXT_RESET_VALUE      32'h0000_2000
`define CMP_RESET_VALUE      8'h00

`endif

/* include/wind_status_pkg.sv */
/*
  Types shared by the status word builder, the host model and the bench.
  Assumes the constants header is included by the design files.
*/
package wind_status_pkg;

  typedef logic [31:0] ext_word_t;
  typedef logic [7:0]  cmp_byte_t;
  typedef logic [15:0] sample_cnt_t;
  typedef logic [15:0] avg_time_t;

  typedef enum logic [1:0]
  {
    RST_PENDING = 2'b01,
    RST_CLEARED = 2'b10
  } restart_state_t;

endpackage

/* test/status_host_model.sv */
/*
  Host model: reads telegrams and pulses the emitted strobe.
  Assumes callers enter just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module status_host_model
(
  input  wire wind_status_pkg::ext_word_t i_extended_status_word,
  input  wire wind_status_pkg::cmp_byte_t i_compact_status_byte,
  input  wire logic                       i_ref_clk,
  output logic                            o_telegram_done
);
  import wind_status_pkg::*;
  ext_word_t cap_ext;
  cmp_byte_t cap_cmp;

  initial o_telegram_done = 1'b0;

  // words are taken when the telegram goes out, before its strobe lands
  task automatic send_telegram();
    cap_ext = i_extended_status_word;
    cap_cmp = i_compact_status_byte;
    o_telegram_done = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_telegram_done = 1'b0;
  endtask
endmodule

`default_nettype wire

/* test/wind_sensor_status_word_builder_bench.sv */
/*
  Self-checking bench for the status word builder.
  Assumes a shortened second of 20 cycles and the host model beside it.
*/
`timescale 1ns/10ps
`default_nettype none

module wind_sensor_status_word_builder_bench;
  import wind_status_pkg::*;
  localparam int unsigned CPS = 20;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        smp = 1'b0, temp_bad = 1'b0, crit = 1'b0, heat = 1'b0, rst_ev = 1'b0;
  logic        tdone;
  sample_cnt_t used = 16'h0000, req = 16'h0010;
  avg_time_t   avg = 16'h0000;
  ext_word_t   ext;
  cmp_byte_t   cmp;
  logic        e_gen = 1'b0, e_crit = 1'b0, e_on = 1'b0, e_stat = 1'b0, e_rst = 1'b1;
  logic [3:0]  e_f16 = 4'h0;
  logic [2:0]  e_f8 = 3'h0;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  wind_status_builder #(.CYCLES_PER_SEC(CPS)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_sample_valid(smp), .i_temp_out_of_range(temp_bad), .i_heat_criterion(crit), .i_heat_on(heat),
    .i_buf_used(used), .i_buf_required(req), .i_avg_time_s(avg), .i_restart(rst_ev),
    .i_telegram_done(tdone), .o_extended_status_word(ext), .o_compact_status_byte(cmp));

  status_host_model u_host (.i_extended_status_word(ext), .i_compact_status_byte(cmp),
    .i_ref_clk(i_ref_clk), .o_telegram_done(tdone));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  function automatic ext_word_t ext_want();
    return {18'h0, e_rst, 1'b0, e_f16, 3'h0, e_stat, 1'b0, e_on, e_crit, e_gen};
  endfunction

  task automatic check_words();
    check(ext, ext_want());
    check({24'h0, cmp}, {24'h0, e_on, e_crit, e_stat, 1'b0, e_f8, e_gen});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_restart();
    u_host.send_telegram();
    check(u_host.cap_ext, ext_want());
    step(2);
    e_rst = 1'b0;
    check_words();
    rst_ev = 1'b1;
    step(1);
    rst_ev = 1'b0;
    step(2);
    e_rst = 1'b1;
    check_words();
    // set beats clear when both land together
    fork
      u_host.send_telegram();
      begin
        rst_ev = 1'b1;
        step(1);
        rst_ev = 1'b0;
      end
    join
    step(3);
    check_words();
    u_host.send_telegram();
    step(2);
    e_rst = 1'b0;
    check_words();
  endtask

  task automatic t_heater();
    crit = 1'b1;
    step(6);
    e_crit = 1'b1;
    check_words();
    heat = 1'b1;
    crit = 1'b0;
    step(6);
    e_on = 1'b1;
    e_crit = 1'b0;
    check_words();
    heat = 1'b0;
    step(6);
    e_on = 1'b0;
    check_words();
  endtask

  task automatic t_fill();
    int ucase[10] = '{0, 1, 2, 3, 4, 5, 8, 9, 15, 16};
    avg = 16'd10;
    foreach (ucase[k])
    begin
      used = 16'(ucase[k]);
      step(2);
      e_f16 = (ucase[k] == 0) ? 4'h0 : 4'(ucase[k] - 1);
      e_f8 = (ucase[k] == 0) ? 3'h0 : 3'((ucase[k] + 1) / 2 - 1);
      e_gen = (ucase[k] < 5);
      check_words();
    end
    req = 16'h0000;
    used = 16'h0004;
    step(2);
    e_f16 = 4'hf;
    e_f8 = 3'h7;
    e_gen = 1'b1;
    check_words();
    req = 16'h0010;
    used = 16'h0010;
    step(2);
    e_gen = 1'b0;
  endtask

  task automatic t_stale();
    avg = 16'd2;
    smp = 1'b1;
    step(1);
    smp = 1'b0;
    step(8 * CPS);
    check_words();
    step(3 * CPS + 2);
    e_gen = 1'b1;
    check_words();
    step(48 * CPS);
    check_words();
    step(3 * CPS);
    e_stat = 1'b1;
    check_words();
    smp = 1'b1;
    step(1);
    smp = 1'b0;
    step(2);
    e_gen = 1'b0;
    e_stat = 1'b0;
    check_words();
    temp_bad = 1'b1;
    step(2);
    e_stat = 1'b1;
    check_words();
    temp_bad = 1'b0;
    step(2);
    e_stat = 1'b0;
    check_words();
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    step(6);
    check_words();
    step(6);
    i_rst_n = 1'b1;
    step(2);
    check_words();
    t_restart();
    t_heater();
    t_fill();
    t_stale();
    conclude();
  end

  // whole run is near 1320 cycles, so this limit only trips on a hang
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    num_errors++;
    conclude();
  end
endmodule

`default_nettype wire
